// ===== bench/ahb_slave_model.sv
// Far side: AHB slave with grant, wait state and error injection
`timescale 1ns/100ps
module ahb_slave_model
    import dma_chan_pkg::*;
(
    // Clock and reset
    input logic clock,
    input logic rst_b,
    // Bus
    input ahb_out_s ahb_out,
    output ahb_in_s ahb_in,
    // Test controls
    input logic slow,
    input logic err_wr,
    // Last good write
    output logic [31:0] last_wdata,
    output logic [31:0] last_waddr
);
    logic dp_r;
    logic wr_r;
    logic wait_r;
    logic gnt_r;
    logic [31:0] ad_r;
    logic [31:0] cnt_r;
    // Reads give ~address; idle data churns
    always_comb begin
        ahb_in.hgrant = gnt_r;
        ahb_in.hready = !(dp_r && wait_r);
        ahb_in.hresp = (dp_r && wr_r && err_wr) ? HRESP_ERROR : HRESP_OKAY;
        ahb_in.hrdata = (dp_r && !wr_r) ? ~ad_r : cnt_r;
    end
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dp_r <= 1'b0;
            wait_r <= 1'b0;
            gnt_r <= 1'b0;
            cnt_r <= 32'h00000000;
        end else begin
            cnt_r <= cnt_r + 32'h01010101;
            gnt_r <= ahb_out.hbusreq;
            if (dp_r && wait_r) begin
                wait_r <= 1'b0;
            end else if (ahb_out.htrans == HTRANS_NONSEQ) begin
                dp_r <= 1'b1;
                ad_r <= ahb_out.haddr;
                wr_r <= ahb_out.hwrite;
                wait_r <= slow;
            end else begin
                dp_r <= 1'b0;
            end
            if (dp_r && !wait_r && wr_r && !err_wr) begin
                last_wdata <= ahb_out.hwdata;
                last_waddr <= ad_r;
            end
        end
    end
endmodule // ahb_slave_model

// ===== bench/dma_chan_checker.sv
// Checker: port-level assertions for one DMA channel
`timescale 1ns/100ps
module dma_chan_checker
    import dma_chan_pkg::*;
(
    // Clock and reset
    input logic clock,
    input logic rst_b,
    // Register port
    input logic [7:0] reg_addr,
    input logic [31:0] reg_wdata,
    input logic reg_wr,
    // Bus
    input ahb_out_s ahb_out,
    input ahb_in_s ahb_in,
    // Handshake
    input logic ext_xfer_ack,
    input logic ext_end_pulse,
    input logic [15:0] periph_end_pulse,
    input logic channel_interrupt
);
    logic [4:0] sel_r;
    logic [1:0] mode_r;
    logic [3:0] dp_r;
    wire any_end = ext_end_pulse || (|periph_end_pulse);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Settings shadow; valid if written when idle
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sel_r <= TRIG_SW;
            mode_r <= MODE_BLOCK;
            dp_r <= 4'h0;
        end else if (reg_wr && reg_addr == OFF_CFG_A) begin
            sel_r <= reg_wdata[28:24];
        end else if (reg_wr && reg_addr == OFF_CFG_B) begin
            mode_r <= reg_wdata[29:28];
            dp_r <= reg_wdata[11:8];
        end
    end
    property p_ack_one;
        ext_xfer_ack |=> !ext_xfer_ack;
    endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("ack too long");
    property p_ack_ok;
        ext_xfer_ack |-> $past(ahb_in.hready)
            && $past(ahb_in.hresp) == HRESP_OKAY;
    endproperty
    a_ack_ok: assert property (p_ack_ok)
        else $error("bad ack");
    property p_end_one;
        $rose(ext_end_pulse) |=> !ext_end_pulse;
    endproperty
    a_end_one: assert property (p_end_one)
        else $error("end too long");
    property p_irq_cause;
        $rose(channel_interrupt) && sel_r != TRIG_SW
            |-> any_end || $past(any_end);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("irq without end");
    property p_prot;
        ahb_out.htrans == HTRANS_NONSEQ && ahb_out.hwrite
            |-> ahb_out.hprot == dp_r;
    endproperty
    a_prot: assert property (p_prot)
        else $error("bad hprot");
    property p_burst_gap;
        mode_r == MODE_BURST && sel_r != TRIG_SW
            && $fell(ahb_out.hbusreq) |-> any_end;
    endproperty
    a_burst_gap: assert property (p_burst_gap)
        else $error("burst gap");
    property p_sw_quiet;
        sel_r == TRIG_SW |-> !ext_xfer_ack && !any_end;
    endproperty
    a_sw_quiet: assert property (p_sw_quiet)
        else $error("handshake in sw run");
    property p_irq_clear;
        reg_wr && reg_addr == OFF_CFG_B && reg_wdata[18:16] == SS_NONE
            && !ahb_out.hbusreq |-> ##[1:2] !channel_interrupt;
    endproperty
    a_irq_clear: assert property (p_irq_clear)
        else $error("irq stuck");
endmodule // dma_chan_checker

// ===== bench/dma_channel_block_burst_ctrl_tb_top.sv
// Testbench: register-driven scenarios for one DMA channel
`timescale 1ns/100ps
module dma_channel_block_burst_ctrl_tb_top
    import dma_chan_pkg::*;
;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    ahb_out_s ahb_out;
    ahb_in_s ahb_in;
    logic ext_xfer_request = 1'b0;
    logic ext_force_stop = 1'b0;
    logic ext_xfer_ack, ext_end_pulse, channel_interrupt;
    logic [15:0] periph_xfer_request = 16'h0000;
    logic [15:0] periph_xfer_ack, periph_end_pulse;
    logic slow = 1'b0, err_wr = 1'b0;
    logic [31:0] last_wdata, last_waddr, d;
    int failures = 0, checked = 0, nack = 0, nend = 0, npack = 0;
    int npend = 0, cyc = 0;
    initial begin
        forever #10 clock = ~clock;
    end
    dma_channel_block_burst_ctrl uut (.clock, .rst_b, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .ahb_out, .ahb_in, .ext_xfer_request,
        .ext_force_stop, .ext_xfer_ack, .ext_end_pulse, .periph_xfer_request,
        .periph_force_stop(16'h0000), .periph_xfer_ack, .periph_end_pulse,
        .channel_interrupt);
    ahb_slave_model bus (.clock, .rst_b, .ahb_out, .ahb_in, .slow, .err_wr,
        .last_wdata, .last_waddr);
    task automatic tally_and_finish;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        nack <= nack + (ext_xfer_ack === 1'b1);
        nend <= nend + (ext_end_pulse === 1'b1);
        npack <= npack + (periph_xfer_ack[3] === 1'b1);
        npend <= npend + (periph_end_pulse[3] === 1'b1);
        if (cyc == 20000) begin
            failures++;
            tally_and_finish;
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        d = reg_rdata;
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        cmp(d, exp);
    endtask
    task automatic start(input logic [31:0] sa, da, b, a);
        wr(OFF_SRC, sa);
        wr(OFF_DST, da);
        wr(OFF_CFG_B, b);
        wr(OFF_CFG_A, a);
    endtask
    // Held three clocks each way for the filter
    task automatic pulse(input int idx);
        for (int k = 0; k < 2; k++) begin
            @(posedge clock);
            if (idx < 0)
                ext_xfer_request <= !ext_xfer_request;
            else
                periph_xfer_request[idx] <= !periph_xfer_request[idx];
            repeat (2) @(posedge clock);
        end
    endtask
    task automatic wait_ss(input logic [2:0] exp);
        for (int i = 0; i < 60; i++) begin
            rd(OFF_CFG_B);
            if (d[18:16] !== SS_NONE)
                break;
        end
        cmp({29'h0, d[18:16]}, {29'h0, exp});
    endtask
    task automatic irq(input logic exp);
        repeat (2) @(negedge clock);
        cmp({31'h0, channel_interrupt}, {31'h0, exp});
    endtask
    initial begin
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        chk(OFF_CFG_B, CFG_RST);
        chk(OFF_SRC, ADDR_RST);
        chk(OFF_DST, ADDR_RST);
        chk(8'h20, 32'h00000000);
        wr(OFF_GLOBAL, 32'h00000001);
        // Block, rising; 2nd edge inside group
        start(32'h100, 32'h200, 32'h08080A00, 32'h8E010001);
        pulse(-1);
        pulse(-1);
        repeat (60) @(posedge clock);
        cmp(nack, 2);
        cmp(nend, 0);
        pulse(-1);
        wait_ss(SS_NORMAL);
        cmp(nack, 4);
        cmp(nend, 1);
        irq(1'b1);
        chk(OFF_SRC, 32'h110);
        chk(OFF_DST, 32'h210);
        cmp(last_wdata, 32'hFFFFFEF3);
        cmp(last_waddr, 32'h20C);
        rd(OFF_CFG_A);
        cmp(d & 32'h000FFFFF, 32'h00000000);
        wr(OFF_CFG_B, 32'h08080A00);
        irq(1'b0);
        // Burst, falling, waits; disabled while pin rises
        slow <= 1'b1;
        wr(OFF_CFG_A, 32'h0F000000);
        ext_xfer_request <= 1'b1;
        start(32'h400, 32'h800, 32'h1A000300, 32'h8F010001);
        pulse(-1);
        pulse(-1);
        wait_ss(SS_NORMAL);
        cmp(nack, 8);
        cmp(nend, 2);
        chk(OFF_SRC, 32'h400);
        chk(OFF_DST, 32'h810);
        cmp(last_wdata, 32'hFFFFFBFF);
        irq(1'b0);
        // Software block, reload; stop ignored
        slow <= 1'b0;
        start(32'h1000, 32'h2000, 32'h08600000, 32'hA0010000);
        ext_force_stop <= 1'b1;
        repeat (4) @(posedge clock);
        ext_force_stop <= 1'b0;
        wait_ss(SS_NORMAL);
        chk(OFF_SRC, 32'h1000);
        chk(OFF_DST, 32'h2000);
        cmp(last_wdata, 32'hFFFFEFFB);
        cmp(last_waddr, 32'h2004);
        cmp(nack + nend, 10);
        // Block, stop in gap
        ext_xfer_request <= 1'b0;
        start(32'h40, 32'h80, 32'h08100000, 32'h8E000001);
        pulse(-1);
        for (int i = 0; i < 100 && nack < 9; i++) @(posedge clock);
        ext_force_stop <= 1'b1;
        repeat (3) @(posedge clock);
        ext_force_stop <= 1'b0;
        wait_ss(SS_STOP);
        cmp(nend, 3);
        irq(1'b1);
        chk(OFF_DST, 32'h84);
        // Peripheral, dst error
        err_wr <= 1'b1;
        start(32'h10, 32'h20, 32'h08100000, 32'h93000000);
        pulse(3);
        wait_ss(SS_DST_ERR);
        cmp(npack, 0);
        cmp(npend, 1);
        irq(1'b1);
        err_wr <= 1'b0;
        tally_and_finish;
    end
endmodule // dma_channel_block_burst_ctrl_tb_top
bind dma_channel_block_burst_ctrl dma_chan_checker chk_i (.clock, .rst_b,
    .reg_addr, .reg_wdata, .reg_wr, .ahb_out, .ahb_in, .ext_xfer_ack,
    .ext_end_pulse, .periph_end_pulse, .channel_interrupt);

// ===== design/dma_chan_pkg.sv
// Package: register layout, codes, states and bus carriers of one DMA channel
// Behaviour
// - Reload-source bit restores source start address.
// - Error interrupt on overflow, stop, disable.
// - Completion interrupt after proper end.
// - Stop status field records end cause.
// - Destination protection drives protection signals.
// - Source address increments unless fixed.
// - Destination address increments unless fixed.
// - Mode field selects block or burst; demand never starts.
// - Block: request moves group, counts decrement.
// - Block: drop bus request after each group.
// - Block: edges ignored while group runs.
// - Block: new edge accepted after acknowledge.
// - Acknowledge pulses after good destination write.
// - End pulse on any hardware-triggered transfer end.
// - Stop input terminates, also in gap.
// - Stop right after request may idle.
// - Software transfers ignore handshake pins.
// - Burst: one request moves block times transfer.
// - Burst: bus request held without gap.
// - Burst: edges ignored until whole transfer ends.
package dma_chan_pkg;

    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_CFG_A = 8'h00;
    localparam logic [7:0] OFF_CFG_B = 8'h04;
    localparam logic [7:0] OFF_SRC = 8'h08;
    localparam logic [7:0] OFF_DST = 8'h0C;
    localparam logic [7:0] OFF_GLOBAL = 8'h10;

    // Reset values
    localparam logic [31:0] ADDR_RST = 32'h00000000;
    localparam logic [31:0] CFG_RST = 32'h00000000;

    // Mode select codes
    localparam logic [1:0] MODE_BLOCK = 2'h0;
    localparam logic [1:0] MODE_BURST = 2'h1;
    localparam logic [1:0] MODE_DEMAND = 2'h2;

    // Stop status codes
    localparam logic [2:0] SS_NONE = 3'h0;
    localparam logic [2:0] SS_OVERFLOW = 3'h1;
    localparam logic [2:0] SS_STOP = 3'h2;
    localparam logic [2:0] SS_SRC_ERR = 3'h3;
    localparam logic [2:0] SS_DST_ERR = 3'h4;
    localparam logic [2:0] SS_NORMAL = 3'h5;
    localparam logic [2:0] SS_DISCONT = 3'h7;

    // Trigger select codes
    localparam logic [4:0] TRIG_SW = 5'h00;
    localparam logic [4:0] TRIG_EXT_RISE = 5'h0E;
    localparam logic [4:0] TRIG_EXT_FALL = 5'h0F;

    // Bus codes
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;
    localparam logic [1:0] HRESP_ERROR = 2'h1;

    typedef struct packed {
        logic channel_enable;
        logic rsv30;
        logic sw_trigger;
        logic [4:0] trigger_select;
        logic [3:0] rsv23;
        logic [3:0] block_count;
        logic [15:0] transfer_count;
    } cfg_a_s;

    typedef struct packed {
        logic [1:0] transfer_type;
        logic [1:0] mode_select;
        logic [1:0] xfer_width;
        logic fixed_src;
        logic fixed_dst;
        logic reload_count;
        logic reload_src_en;
        logic reload_dst_en;
        logic error_irq_en;
        logic completion_irq_en;
        logic [2:0] stop_status;
        logic [3:0] src_protect_code;
        logic [3:0] dst_protect_code;
        logic [7:0] rsv;
    } cfg_b_s;

    typedef struct packed {
        logic hbusreq;
        logic [1:0] htrans;
        logic [31:0] haddr;
        logic hwrite;
        logic [2:0] hsize;
        logic [3:0] hprot;
        logic [31:0] hwdata;
    } ahb_out_s;

    typedef struct packed {
        logic hgrant;
        logic hready;
        logic [1:0] hresp;
        logic [31:0] hrdata;
    } ahb_in_s;

    typedef enum logic [3:0] {
        PH_IDLE,
        PH_BUSREQ,
        PH_SRC_ADDR,
        PH_SRC_DATA,
        PH_DST_ADDR,
        PH_DST_DATA,
        PH_GAP
    } phase_e;

endpackage

// ===== design/dma_channel_block_burst_ctrl.sv
// Single DMA channel: registers, trigger logic and bus master sequencer
`timescale 1ns/100ps
module dma_channel_block_burst_ctrl
    import dma_chan_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Bus master
    output ahb_out_s ahb_out,
    input wire ahb_in_s ahb_in,
    // Requester handshake
    input wire logic ext_xfer_request,
    input wire logic ext_force_stop,
    output logic ext_xfer_ack,
    output logic ext_end_pulse,
    input wire logic [15:0] periph_xfer_request,
    input wire logic [15:0] periph_force_stop,
    output logic [15:0] periph_xfer_ack,
    output logic [15:0] periph_end_pulse,
    // Interrupt level
    output logic channel_interrupt
);

    typedef struct packed {
        phase_e phase;
        cfg_a_s cfg_a;
        cfg_b_s cfg_b;
        logic global_enable;
        logic [31:0] src_addr;
        logic [31:0] dst_addr;
        logic [31:0] src_start;
        logic [31:0] dst_start;
        logic [3:0] bc_start;
        logic [31:0] data_buf;
        logic hw_trig;
        logic [4:0] run_sel;
        logic [33:0] sync1;
        logic [33:0] sync2;
        logic [33:0] sync3;
        logic [33:0] filt;
        logic req_prev;
        logic ack;
        logic eop;
        logic irq;
        logic dph;
        logic [31:0] rd_data;
        ahb_out_s bus;
    } chan_state_s;

    logic rst_meta_r;
    logic rst_sync_b_r;
    chan_state_s q_r;
    chan_state_s q_nxt;

    // Reset is released through two flops so the struct leaves reset cleanly
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_r <= 1'b0;
            rst_sync_b_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_b_r <= rst_meta_r;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    // Combinational view of selected trigger
    logic [15:0] preq_lvl;
    logic [15:0] pstop_lvl;
    logic sel_ext;
    logic sel_per;
    logic sel_hw;
    logic req_lvl;
    logic req_edge;
    logic stop_lvl;
    logic run_ext;
    logic run_per;

    always_comb begin
        preq_lvl = q_r.filt[17:2];
        pstop_lvl = q_r.filt[33:18];
        sel_ext = (q_r.cfg_a.trigger_select == TRIG_EXT_RISE) ||
            (q_r.cfg_a.trigger_select == TRIG_EXT_FALL);
        sel_per = q_r.cfg_a.trigger_select[4];
        sel_hw = sel_ext || sel_per;
        // Falling-edge code inverts the pin so one edge detector serves all
        if (sel_per) begin
            req_lvl = preq_lvl[q_r.cfg_a.trigger_select[3:0]];
        end else if (q_r.cfg_a.trigger_select == TRIG_EXT_FALL) begin
            req_lvl = !q_r.filt[0];
        end else begin
            req_lvl = sel_ext && q_r.filt[0];
        end

        req_edge = req_lvl && !q_r.req_prev;

        run_ext = !q_r.run_sel[4];
        run_per = q_r.run_sel[4];
        if (run_per) begin
            stop_lvl = q_r.hw_trig && pstop_lvl[q_r.run_sel[3:0]];
        end else begin
            stop_lvl = q_r.hw_trig && q_r.filt[1];
        end
    end

    logic enabled;
    logic [32:0] src_sum;
    logic [32:0] dst_sum;
    logic [32:0] step;
    logic data_rdy;

    always_comb begin
        enabled = q_r.cfg_a.channel_enable && q_r.global_enable;
        step = 33'h000000001 << q_r.cfg_b.xfer_width;
        src_sum = {1'b0, q_r.src_addr} + step;
        dst_sum = {1'b0, q_r.dst_addr} + step;

        // Data phase is the cycle after the address phase
        data_rdy = q_r.dph && ahb_in.hready;
    end

    always_comb begin
        q_nxt = q_r;
        q_nxt.ack = 1'b0;
        q_nxt.eop = 1'b0;
        q_nxt.rd_data = 32'h00000000;
        q_nxt.bus.htrans = HTRANS_IDLE;
        q_nxt.dph = 1'b0;



        // Three-flop sync; a level counts once stages two and three agree
        q_nxt.sync1 = {periph_force_stop, periph_xfer_request,
            ext_force_stop, ext_xfer_request};
        q_nxt.sync2 = q_r.sync1;
        q_nxt.sync3 = q_r.sync2;
        q_nxt.filt = (q_r.sync2 & q_r.sync3) |
            (q_r.filt & (q_r.sync2 ^ q_r.sync3));
        // Edges not looked at during a run are dropped on purpose
        q_nxt.req_prev = req_lvl;


        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                OFF_CFG_A: begin
                    q_nxt.cfg_a = reg_wdata;
                    q_nxt.cfg_a.rsv30 = 1'b0;
                    q_nxt.cfg_a.rsv23 = 4'h0;
                end
                OFF_CFG_B: begin
                    q_nxt.cfg_b = reg_wdata;
                    q_nxt.cfg_b.rsv = 8'h00;
                    // Status can only be cleared, never loaded
                    if (reg_wdata[18:16] != SS_NONE) begin
                        q_nxt.cfg_b.stop_status = q_r.cfg_b.stop_status;
                    end else begin
                        q_nxt.cfg_b.stop_status = SS_NONE;
                    end
                end
                OFF_SRC: q_nxt.src_addr = reg_wdata;
                OFF_DST: q_nxt.dst_addr = reg_wdata;
                OFF_GLOBAL: q_nxt.global_enable = reg_wdata[0];
                default: ;
            endcase
        end


        // Register reads, answered next cycle
        if (reg_rd) begin
            unique case (reg_addr)
                OFF_CFG_A: q_nxt.rd_data = q_r.cfg_a;
                OFF_CFG_B: q_nxt.rd_data = q_r.cfg_b;
                OFF_SRC: q_nxt.rd_data = q_r.src_addr;
                OFF_DST: q_nxt.rd_data = q_r.dst_addr;
                OFF_GLOBAL: q_nxt.rd_data = {31'h00000000, q_r.global_enable};
                default: q_nxt.rd_data = 32'h00000000;
            endcase
        end


        // Sequencer; hardware status updates below win over a clearing write
        unique case (q_r.phase)
            PH_IDLE: begin
                q_nxt.bus.hbusreq = 1'b0;
                // Demand and reserved modes never start here
                if (enabled && (q_r.cfg_b.mode_select == MODE_BLOCK ||
                    q_r.cfg_b.mode_select == MODE_BURST)) begin
                    if (q_r.cfg_a.sw_trigger &&
                        q_r.cfg_a.trigger_select == TRIG_SW) begin
                        q_nxt.hw_trig = 1'b0;
                        q_nxt.run_sel = q_r.cfg_a.trigger_select;
                        q_nxt.src_start = q_r.src_addr;
                        q_nxt.dst_start = q_r.dst_addr;
                        q_nxt.bc_start = q_r.cfg_a.block_count;
                        q_nxt.phase = PH_BUSREQ;
                    end else if (!q_r.cfg_a.sw_trigger && sel_hw &&
                        req_edge) begin
                        q_nxt.hw_trig = 1'b1;
                        q_nxt.run_sel = q_r.cfg_a.trigger_select;
                        q_nxt.src_start = q_r.src_addr;
                        q_nxt.dst_start = q_r.dst_addr;
                        q_nxt.bc_start = q_r.cfg_a.block_count;
                        q_nxt.phase = PH_BUSREQ;
                    end
                end
            end

            PH_BUSREQ: begin
                q_nxt.bus.hbusreq = 1'b1;
                // Stop while waiting for the bus ends the run before the next beat
                if (stop_lvl) begin
                    q_nxt.cfg_b.stop_status = SS_STOP;
                    q_nxt.eop = q_r.hw_trig;
                    q_nxt.cfg_a.sw_trigger = 1'b0;
                    q_nxt.bus.hbusreq = 1'b0;
                    q_nxt.phase = PH_IDLE;
                end else if (ahb_in.hgrant && ahb_in.hready) begin
                    q_nxt.phase = PH_SRC_ADDR;
                end
            end

            PH_SRC_ADDR: begin
                q_nxt.bus.htrans = HTRANS_NONSEQ;
                q_nxt.bus.haddr = q_r.src_addr;
                q_nxt.bus.hwrite = 1'b0;
                q_nxt.bus.hsize = {1'b0, q_r.cfg_b.xfer_width};
                q_nxt.bus.hprot = q_r.cfg_b.src_protect_code;
                q_nxt.phase = PH_SRC_DATA;
            end

            PH_SRC_DATA: begin
                // One beat in flight, so the address phase never waits
                q_nxt.dph = !q_r.dph || !ahb_in.hready;
                if (data_rdy) begin
                    if (ahb_in.hresp == HRESP_OKAY) begin
                        q_nxt.data_buf = ahb_in.hrdata;
                        q_nxt.phase = PH_DST_ADDR;
                        if (!q_r.cfg_b.fixed_src) begin
                            q_nxt.src_addr = src_sum[31:0];
                        end
                    end else if (ahb_in.hresp == HRESP_ERROR) begin
                        q_nxt.cfg_b.stop_status = SS_SRC_ERR;
                        q_nxt.eop = q_r.hw_trig;
                        q_nxt.cfg_a.sw_trigger = 1'b0;
                        q_nxt.bus.hbusreq = 1'b0;
                        q_nxt.phase = PH_IDLE;
                    end else begin
                        // Retry or split: reissue the same source beat
                        q_nxt.phase = PH_BUSREQ;
                    end
                end
            end

            PH_DST_ADDR: begin
                q_nxt.bus.htrans = HTRANS_NONSEQ;
                q_nxt.bus.haddr = q_r.dst_addr;
                q_nxt.bus.hwrite = 1'b1;
                q_nxt.bus.hsize = {1'b0, q_r.cfg_b.xfer_width};
                q_nxt.bus.hprot = q_r.cfg_b.dst_protect_code;
                q_nxt.bus.hwdata = q_r.data_buf;
                q_nxt.phase = PH_DST_DATA;
            end

            PH_DST_DATA: begin
                q_nxt.dph = !q_r.dph || !ahb_in.hready;
                if (data_rdy && ahb_in.hresp == HRESP_ERROR) begin
                    q_nxt.cfg_b.stop_status = SS_DST_ERR;
                    q_nxt.eop = q_r.hw_trig;
                    q_nxt.cfg_a.sw_trigger = 1'b0;
                    q_nxt.bus.hbusreq = 1'b0;
                    q_nxt.phase = PH_IDLE;
                end else if (data_rdy && ahb_in.hresp != HRESP_OKAY) begin
                    q_nxt.phase = PH_BUSREQ;
                end else if (data_rdy) begin
                    q_nxt.ack = q_r.hw_trig;
                    if (!q_r.cfg_b.fixed_dst) begin
                        q_nxt.dst_addr = dst_sum[31:0];
                    end
                    if ((!q_r.cfg_b.fixed_src && src_sum[32]) ||
                        (!q_r.cfg_b.fixed_dst && dst_sum[32])) begin
                        q_nxt.cfg_b.stop_status = SS_OVERFLOW;
                        q_nxt.eop = q_r.hw_trig;
                        q_nxt.cfg_a.sw_trigger = 1'b0;
                        q_nxt.bus.hbusreq = 1'b0;
                        q_nxt.phase = PH_IDLE;
                    end else if (stop_lvl) begin
                        q_nxt.cfg_b.stop_status = SS_STOP;
                        q_nxt.eop = 1'b1;
                        q_nxt.bus.hbusreq = 1'b0;
                        q_nxt.phase = PH_IDLE;
                    end else if (q_r.cfg_a.block_count != 4'h0) begin
                        q_nxt.cfg_a.block_count =
                            q_r.cfg_a.block_count - 4'h1;
                        q_nxt.phase = PH_BUSREQ;
                    end else if (q_r.cfg_a.transfer_count != 16'h0000) begin
                        q_nxt.cfg_a.transfer_count =
                            q_r.cfg_a.transfer_count - 16'h0001;
                        q_nxt.cfg_a.block_count = q_r.bc_start;
                        if (q_r.cfg_b.mode_select == MODE_BURST) begin
                            q_nxt.phase = PH_BUSREQ;
                        end else begin
                            q_nxt.bus.hbusreq = 1'b0;
                            q_nxt.phase = PH_GAP;
                        end
                    end else begin
                        q_nxt.cfg_b.stop_status = SS_NORMAL;
                        q_nxt.eop = q_r.hw_trig;
                        q_nxt.cfg_a.sw_trigger = 1'b0;
                        q_nxt.bus.hbusreq = 1'b0;
                        q_nxt.phase = PH_IDLE;
                        if (q_r.cfg_b.reload_src_en) begin
                            q_nxt.src_addr = q_r.src_start;
                        end
                        if (q_r.cfg_b.reload_dst_en) begin
                            q_nxt.dst_addr = q_r.dst_start;
                        end
                    end
                end
            end

            PH_GAP: begin
                // Bus request dropped; register changes act here
                q_nxt.bus.hbusreq = 1'b0;
                if (stop_lvl) begin
                    q_nxt.cfg_b.stop_status = SS_STOP;
                    q_nxt.eop = 1'b1;
                    q_nxt.phase = PH_IDLE;
                end else if (!enabled ||
                    (!q_r.hw_trig && !q_r.cfg_a.sw_trigger)) begin
                    q_nxt.cfg_b.stop_status = SS_DISCONT;
                    q_nxt.eop = q_r.hw_trig;
                    q_nxt.cfg_a.sw_trigger = 1'b0;
                    q_nxt.phase = PH_IDLE;
                end else if (!q_r.hw_trig || req_edge) begin
                    q_nxt.phase = PH_BUSREQ;
                end
            end
        endcase


        // Interrupt level follows status and enables
        unique case (q_nxt.cfg_b.stop_status)
            SS_OVERFLOW, SS_STOP, SS_SRC_ERR, SS_DST_ERR, SS_DISCONT:
                q_nxt.irq = q_nxt.cfg_b.error_irq_en;
            SS_NORMAL:
                q_nxt.irq = q_nxt.cfg_b.completion_irq_en;
            default:
                q_nxt.irq = 1'b0;
        endcase
    end

    // Outputs
    always_comb begin
        reg_rdata = q_r.rd_data;
        ahb_out = q_r.bus;
        channel_interrupt = q_r.irq;
        // Pulses reach only the requester that started the run
        ext_xfer_ack = q_r.ack && run_ext;
        ext_end_pulse = q_r.eop && run_ext;
        periph_xfer_ack = {15'h0000, q_r.ack && run_per} << q_r.run_sel[3:0];
        periph_end_pulse = {15'h0000, q_r.eop && run_per} << q_r.run_sel[3:0];
    end

endmodule // dma_channel_block_burst_ctrl
